// File: design/edge_counter.sv
// Counts link clock edges; count passes to the system domain as gray code
`timescale 1ns/1ps
module edge_counter #(
    parameter int WIDTH = 12
) (
    // Link clock side
    input  wire logic             link_clock,
    input  wire logic             link_rst,
    // Gray coded running count, registered in the link domain
    output logic      [WIDTH-1:0] count_gray
);
    logic [WIDTH-1:0] count_bin;
    logic [WIDTH-1:0] next_bin;

    assign next_bin = count_bin + WIDTH'(1);

    // Gray code lets the reader sample across domains with one bit moving at a time
    always_ff @(posedge link_clock) begin
        if (link_rst) begin
            count_bin  <= '0;
            count_gray <= '0;
        end else begin
            count_bin  <= next_bin;
            count_gray <= next_bin ^ (next_bin >> 1);
        end
    end
endmodule

// File: design/level_sync.sv
// Two-stage synchroniser for a level
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] first_stage;

    always_ff @(posedge clock) begin
        if (rst) begin
            first_stage <= '0;
            sync_out    <= '0;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end
endmodule

// File: design/tmds_clock_freq_monitor.sv
// TMDS clock frequency monitor: measure, threshold, settle, and policy registers
//
// How it works
// - Swap-autocorrect-off stops automatic swap correction
// - Swap bit writable only when autocorrect off
// - Link-ready override forces link ready output
// - Clock-present override forces valid clock report
// - Stable after dwell time inside hysteresis band
// - Dwell codes: 40, 80, 320, 1280 us
// - Capture new reading only beyond hysteresis
// - PHY reset on change unless policy and +5V
// - Low limit flags clock too slow
// - Seven-bit high limit, default 0x44 (68 MHz)
// - Measured register returns whole MHz
// - Measured reads zero without valid signal
// - Settled flag when frequency stable
// - PLL reset pulse on change when enabled
// - Source select: raw clock or PLL clock
`timescale 1ns/1ps
module tmds_clock_freq_monitor
    import tmds_freq_pkg::*;
#(
    parameter int CNT_WIDTH    = 12,
    parameter int DWELL3_CYCLES = DWELL3_US * CLOCK_MHZ
) (
    // System clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Measured clocks
    input  wire logic       tmds_clock,
    input  wire logic       pll_clock,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pins and link status
    input  wire logic       power_detect,
    input  wire logic       back_channel_ok,
    input  wire logic       swap_detected,
    input  wire logic       mode_change,
    // Outputs
    output logic            link_ready,
    output logic            clock_valid,
    output logic            phy_reset,
    output logic            pll_reset,
    output logic            swap_active
);
    import tmds_freq_pkg::*;

    localparam int DW0 = DWELL0_US * CLOCK_MHZ;
    localparam int DW1 = DWELL1_US * CLOCK_MHZ;
    localparam int DW2 = DWELL2_US * CLOCK_MHZ;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] dual_link_control_one;
    logic [7:0] dual_link_control_two;
    logic [7:0] low_frequency_limit;
    logic [7:0] high_frequency_limit;
    logic [7:0] measured_freq_mhz;
    logic       freq_settled_flag;
    logic       no_clock_flag;

    logic       swap_auto_off;
    logic       source_select;
    logic [1:0] stability_time_select;
    logic [2:0] measure_hysteresis;
    logic [5:0] low_freq_limit_field;
    logic [6:0] high_freq_limit_field;

    assign swap_auto_off         = dual_link_control_two[SWAP_AUTO_OFF];
    assign source_select         = dual_link_control_one[SOURCE_SEL_BIT];
    assign stability_time_select = dual_link_control_two[STAB_HI:STAB_LO];
    assign measure_hysteresis    = dual_link_control_two[2:0];
    assign low_freq_limit_field  = low_frequency_limit[5:0];
    assign high_freq_limit_field = high_frequency_limit[6:0];

    always_ff @(posedge clock) begin
        if (rst) begin
            dual_link_control_two <= DUAL_TWO_RESET;
            low_frequency_limit   <= LOW_RESET;
            high_frequency_limit  <= HIGH_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_DUAL_TWO:  dual_link_control_two <= reg_wdata;
                ADDR_LOW_LIMIT: low_frequency_limit   <= reg_wdata & 8'h7F;
                ADDR_HIGH_LIM:  high_frequency_limit  <= reg_wdata & 8'h7F;
                default: ;
            endcase
        end
    end

    // Swap state: software owns it only with autocorrect off
    always_ff @(posedge clock) begin
        if (rst) begin
            dual_link_control_one <= DUAL_ONE_RESET;
        end else begin
            if (reg_write && reg_addr == ADDR_DUAL_ONE) begin
                dual_link_control_one[5:0] <= reg_wdata[5:0];
                dual_link_control_one[7]   <= reg_wdata[7];
                if (swap_auto_off)
                    dual_link_control_one[SWAP_STATE_BIT] <= reg_wdata[SWAP_STATE_BIT];
            end
            if (!swap_auto_off && swap_detected)
                dual_link_control_one[SWAP_STATE_BIT] <= ~dual_link_control_one[SWAP_STATE_BIT];
        end
    end
    assign swap_active = dual_link_control_one[SWAP_STATE_BIT];

    always_comb begin
        case (reg_addr)
            ADDR_DUAL_ONE:  reg_rdata = dual_link_control_one;
            ADDR_DUAL_TWO:  reg_rdata = dual_link_control_two;
            ADDR_LOW_LIMIT: reg_rdata = low_frequency_limit;
            ADDR_HIGH_LIM:  reg_rdata = high_frequency_limit;
            ADDR_MEASURED:  reg_rdata = measured_freq_mhz;
            ADDR_STATUS:    reg_rdata = {6'h00, no_clock_flag, freq_settled_flag};
            default:        reg_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Measurement: link clock edge counters and crossing
    // ------------------------------------------------------------
    logic                 tmds_rst;
    logic                 pll_rst;
    logic [CNT_WIDTH-1:0] tmds_gray;
    logic [CNT_WIDTH-1:0] pll_gray;
    logic [CNT_WIDTH-1:0] tmds_gray_sync;
    logic [CNT_WIDTH-1:0] pll_gray_sync;
    logic [CNT_WIDTH-1:0] sel_gray;
    logic [CNT_WIDTH-1:0] sel_bin;
    logic [CNT_WIDTH-1:0] last_bin;
    logic [CNT_WIDTH-1:0] delta;
    logic [15:0]          gate_count;
    logic                 gate_done;
    logic                 reading_ready;
    logic                 link_hold;
    logic                 source_prev;
    logic                 skip_gate;
    logic                 gate_valid;

    // A reset shorter than a link period would miss the link counters, so the
    // request stands until the first gate closes; a very slow link clock can still miss it
    always_ff @(posedge clock) begin
        if (rst)
            link_hold <= 1'b1;
        else if (gate_done)
            link_hold <= 1'b0;
    end

    // Reset reaches the link domains through synchronisers of their own
    level_sync #(.WIDTH(1)) tmds_rst_sync (
        .clock    (tmds_clock),
        .rst      (1'b0),
        .async_in (link_hold),
        .sync_out (tmds_rst)
    );
    level_sync #(.WIDTH(1)) pll_rst_sync (
        .clock    (pll_clock),
        .rst      (1'b0),
        .async_in (link_hold),
        .sync_out (pll_rst)
    );
    edge_counter #(.WIDTH(CNT_WIDTH)) tmds_counter (
        .link_clock (tmds_clock),
        .link_rst   (tmds_rst),
        .count_gray (tmds_gray)
    );
    edge_counter #(.WIDTH(CNT_WIDTH)) pll_counter (
        .link_clock (pll_clock),
        .link_rst   (pll_rst),
        .count_gray (pll_gray)
    );
    level_sync #(.WIDTH(CNT_WIDTH)) tmds_cross (
        .clock    (clock),
        .rst      (rst),
        .async_in (tmds_gray),
        .sync_out (tmds_gray_sync)
    );
    level_sync #(.WIDTH(CNT_WIDTH)) pll_cross (
        .clock    (clock),
        .rst      (rst),
        .async_in (pll_gray),
        .sync_out (pll_gray_sync)
    );

    assign sel_gray = source_select ? pll_gray_sync : tmds_gray_sync;

    always_comb begin
        sel_bin[CNT_WIDTH-1] = sel_gray[CNT_WIDTH-1];
        for (int i = CNT_WIDTH - 2; i >= 0; i--) begin
            sel_bin[i] = sel_bin[i+1] ^ sel_gray[i];
        end
    end

    assign delta     = sel_bin - last_bin;
    assign gate_done = (gate_count == 16'(GATE_CYCLES - 1));

    // A gate in which the source changed mixes two counters; its count is thrown away
    assign gate_valid = gate_done && !skip_gate && (source_select == source_prev);

    always_ff @(posedge clock) begin
        if (rst) begin
            source_prev <= 1'b0;
            skip_gate   <= 1'b0;
        end else begin
            source_prev <= source_select;
            if (source_select != source_prev)
                skip_gate <= 1'b1;
            else if (gate_done)
                skip_gate <= 1'b0;
        end
    end

    // One microsecond gate: edges counted in it equal the frequency in MHz
    always_ff @(posedge clock) begin
        if (rst) begin
            gate_count    <= 16'h0000;
            last_bin      <= '0;
            reading_ready <= 1'b0;
        end else begin
            reading_ready <= gate_valid;
            if (gate_done) begin
                gate_count <= 16'h0000;
                last_bin   <= sel_bin;
            end else begin
                gate_count <= gate_count + 16'h0001;
            end
        end
    end

    logic [7:0] raw_mhz;
    logic [7:0] diff_mhz;
    logic       too_slow;
    logic       too_fast;
    logic       outside_band;
    logic       freq_change;

    always_ff @(posedge clock) begin
        if (rst)
            raw_mhz <= 8'h00;
        else if (gate_valid)
            raw_mhz <= (delta > CNT_WIDTH'(255)) ? 8'hFF : delta[7:0];
    end

    assign too_slow = raw_mhz <= {2'b00, low_freq_limit_field};
    assign too_fast = raw_mhz > {1'b0, high_freq_limit_field};

    assign diff_mhz     = (raw_mhz > measured_freq_mhz) ? raw_mhz - measured_freq_mhz
                                                       : measured_freq_mhz - raw_mhz;
    assign outside_band = diff_mhz > {5'b00000, measure_hysteresis};
    assign freq_change  = reading_ready && !too_slow && outside_band;

    always_ff @(posedge clock) begin
        if (rst) begin
            measured_freq_mhz <= 8'h00;
        end else if (reading_ready) begin
            if (too_slow)
                measured_freq_mhz <= 8'h00;
            else if (outside_band)
                measured_freq_mhz <= raw_mhz;
        end
    end

    always_ff @(posedge clock) begin
        if (rst)
            no_clock_flag <= 1'b1;
        else if (reading_ready)
            no_clock_flag <= too_slow;
    end

    // ------------------------------------------------------------
    // Stability dwell
    // ------------------------------------------------------------
    logic [31:0] dwell_limit;
    logic [31:0] dwell_count;

    always_comb begin
        case (stability_time_select)
            2'b00:   dwell_limit = 32'(DW0);
            2'b01:   dwell_limit = 32'(DW1);
            2'b10:   dwell_limit = 32'(DW2);
            default: dwell_limit = 32'(DWELL3_CYCLES);
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dwell_count       <= 32'h00000000;
            freq_settled_flag <= 1'b0;
        end else if (reading_ready && (too_slow || outside_band)) begin
            dwell_count       <= 32'h00000000;
            freq_settled_flag <= 1'b0;
        end else if (!no_clock_flag && !freq_settled_flag) begin
            if (dwell_count >= dwell_limit - 32'h00000001)
                freq_settled_flag <= 1'b1;
            else
                dwell_count <= dwell_count + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // Outputs and reset policy
    // ------------------------------------------------------------
    logic       power_sync;
    logic       back_sync;
    logic [2:0] phy_timer;
    logic       mode_prev;

    level_sync #(.WIDTH(2)) pin_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({power_detect, back_channel_ok}),
        .sync_out ({power_sync, back_sync})
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            link_ready  <= 1'b0;
            clock_valid <= 1'b0;
            pll_reset   <= 1'b0;
            mode_prev   <= 1'b0;
        end else begin
            link_ready  <= back_sync | dual_link_control_two[LINK_RDY_OVR];
            clock_valid <= dual_link_control_two[CLK_PRESENT_OVR] |
                           (freq_settled_flag & !no_clock_flag & !too_fast);
            pll_reset   <= freq_change & dual_link_control_one[PLL_RESET_BIT];
            mode_prev   <= mode_change;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phy_timer <= 3'h0;
        end else if ((freq_change || (mode_change && !mode_prev)) &&
                     !(low_frequency_limit[PHY_POLICY_BIT] && power_sync)) begin
            phy_timer <= 3'(PHY_PULSE_CYC);
        end else if (phy_timer != 3'h0) begin
            phy_timer <= phy_timer - 3'h1;
        end
    end
    assign phy_reset = phy_timer != 3'h0;
endmodule

// File: design/tmds_freq_pkg.sv
// Shared constants for the TMDS clock frequency monitor
package tmds_freq_pkg;
    // Register addresses on the serial control port
    localparam logic [7:0] ADDR_DUAL_ONE  = 8'h5B;
    localparam logic [7:0] ADDR_DUAL_TWO  = 8'h5C;
    localparam logic [7:0] ADDR_LOW_LIMIT = 8'h5D;
    localparam logic [7:0] ADDR_HIGH_LIM  = 8'h5E;
    localparam logic [7:0] ADDR_MEASURED  = 8'h5F;
    localparam logic [7:0] ADDR_STATUS    = 8'h5A;
    // Field positions
    localparam int SWAP_STATE_BIT   = 6;
    localparam int PLL_RESET_BIT    = 5;
    localparam int SOURCE_SEL_BIT   = 4;
    localparam int SWAP_AUTO_OFF    = 7;
    localparam int LINK_RDY_OVR     = 6;
    localparam int CLK_PRESENT_OVR  = 5;
    localparam int STAB_HI          = 4;
    localparam int STAB_LO          = 3;
    localparam int PHY_POLICY_BIT   = 6;
    // Reset values
    localparam logic [7:0] DUAL_ONE_RESET = 8'h20;
    localparam logic [7:0] DUAL_TWO_RESET = 8'h02;
    localparam logic [7:0] LOW_RESET      = 8'h06;
    localparam logic [7:0] HIGH_RESET     = 8'h44;
    // Timing
    localparam int CLOCK_MHZ     = 200;
    localparam int GATE_US       = 1;
    localparam int GATE_CYCLES   = GATE_US * CLOCK_MHZ;
    localparam int DWELL0_US     = 40;
    localparam int DWELL1_US     = 80;
    localparam int DWELL2_US     = 320;
    localparam int DWELL3_US     = 1280;
    localparam int PHY_PULSE_CYC = 4;
endpackage

// File: testbench/tb_tmds_clock_freq_monitor.sv
// Self-checking bench for the TMDS clock frequency monitor
`timescale 1ns/1ps
module tb_tmds_clock_freq_monitor;
    import tmds_freq_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } row_type;
    logic       clock, rst, tmds_clock, pll_clock, src_on, reg_write, phy_q;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic       power_detect, back_channel_ok, swap_detected, mode_change;
    logic       link_ready, clock_valid, phy_reset, pll_reset, swap_active;
    logic [2:0] outs;
    int         err_count, total_checks, pll_n, phy_n, n, k;
    // First six rows only read reset values; the rest write, then read back
    row_type    rows [19] = '{24'h5B0020, 24'h5C0002, 24'h5D0006, 24'h5E0044, 24'h5F0000,
        24'h5A0002, 24'h5DFF7F, 24'h5EFF7F, 24'h5FAA00, 24'h5AFF02, 24'h105500, 24'h5B4000,
        24'h5C8080, 24'h5B4040, 24'h5B2020, 24'h5C0202, 24'h5D0606, 24'h5E4444, 24'h5B2020};
    // ----------------
    // Instances
    // ----------------
    tmds_source_model i_src (.enable(src_on), .tmds_clock(tmds_clock), .pll_clock(pll_clock));
    tmds_clock_freq_monitor #(.DWELL3_CYCLES(400)) i_dut (.clock(clock), .rst(rst),
        .tmds_clock(tmds_clock), .pll_clock(pll_clock), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .power_detect(power_detect), .back_channel_ok(back_channel_ok),
        .swap_detected(swap_detected), .mode_change(mode_change), .link_ready(link_ready),
        .clock_valid(clock_valid), .phy_reset(phy_reset), .pll_reset(pll_reset),
        .swap_active(swap_active));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Outputs are snapshotted mid-cycle so checks never race the launching edge
    always @(negedge clock) begin
        outs <= {link_ready, clock_valid, swap_active};
        phy_q <= phy_reset;
        if (pll_reset === 1'b1) pll_n++;
        if (phy_reset === 1'b1 && phy_q !== 1'b1) phy_n++;
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Polls a register field; running out of polls ends the run
    task automatic wait_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        rd(a);
        for (int i = 0; i < 12000 && (d & m) !== v; i++) rd(a);
        chk(d & m, v);
        if ((d & m) !== v) print_verdict();
    endtask
    task automatic pulse_in(input bit sel);
        if (sel) swap_detected <= 1'b1;
        else mode_change <= 1'b1;
        tick(1);
        swap_detected <= 1'b0;
        mode_change <= 1'b0;
        tick(10);
    endtask
    initial begin
        {rst, src_on} = 2'b11;
        {reg_addr, reg_wdata, reg_write, d} = 25'h0;
        {power_detect, back_channel_ok, swap_detected, mode_change} = 4'h0;
        tick(12);
        rst <= 1'b0;
        tick(1);
        foreach (rows[i]) begin
            if (i > 5) wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr);
            chk(d, rows[i].exp);
        end
        wait_reg(ADDR_MEASURED, 8'hFF, 8'h08);
        wait_reg(ADDR_STATUS, 8'hFF, 8'h01);
        tick(2);
        chk({7'h00, outs[1]}, 8'h01);
        {n, k} = {pll_n, phy_n};
        wr(ADDR_DUAL_ONE, 8'h30);
        tick(1000);
        rd(ADDR_MEASURED);
        chk(d, 8'h08);
        // Longest dwell code, shortened to 400 cycles at the instance
        wr(ADDR_DUAL_TWO, 8'h19);
        wait_reg(ADDR_MEASURED, 8'hFF, 8'h0A);
        tick(8);
        rd(ADDR_STATUS);
        chk(d & 8'h01, 8'h00);
        chk(8'(pll_n - n), 8'h01);
        chk(8'(phy_n - k), 8'h01);
        n = pll_n;
        wr(ADDR_DUAL_ONE, 8'h00);
        wait_reg(ADDR_MEASURED, 8'hFF, 8'h08);
        tick(8);
        chk(8'(pll_n - n), 8'h00);
        tick(370);
        rd(ADDR_STATUS);
        chk(d & 8'h01, 8'h00);
        tick(25);
        rd(ADDR_STATUS);
        chk(d & 8'h01, 8'h01);
        src_on <= 1'b0;
        wait_reg(ADDR_MEASURED, 8'hFF, 8'h00);
        wait_reg(ADDR_STATUS, 8'h02, 8'h02);
        chk({7'h00, outs[1]}, 8'h00);
        wr(ADDR_DUAL_TWO, 8'h21);
        tick(4);
        chk({7'h00, outs[1]}, 8'h01);
        chk({7'h00, outs[2]}, 8'h00);
        wr(ADDR_DUAL_TWO, 8'h61);
        tick(4);
        chk({7'h00, outs[2]}, 8'h01);
        wr(ADDR_LOW_LIMIT, 8'h46);
        power_detect <= 1'b1;
        tick(4);
        k = phy_n;
        pulse_in(1'b0);
        chk(8'(phy_n - k), 8'h00);
        power_detect <= 1'b0;
        tick(4);
        pulse_in(1'b0);
        chk(8'(phy_n - k), 8'h01);
        pulse_in(1'b1);
        chk({7'h00, outs[0]}, 8'h01);
        wr(ADDR_DUAL_TWO, 8'h81);
        pulse_in(1'b1);
        chk({7'h00, outs[0]}, 8'h01);
        wr(ADDR_DUAL_ONE, 8'h00);
        tick(3);
        chk({7'h00, outs[0]}, 8'h00);
        print_verdict();
    end
endmodule
bind tmds_clock_freq_monitor tmds_freq_asserts i_chk (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .swap_detected(swap_detected), .link_ready(link_ready), .clock_valid(clock_valid),
    .phy_reset(phy_reset), .pll_reset(pll_reset), .swap_active(swap_active));

// File: testbench/tmds_freq_asserts.sv
// Port checker for the TMDS clock frequency monitor
`timescale 1ns/1ps
module tmds_freq_asserts
    import tmds_freq_pkg::*;
(
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Link status and outputs
    input wire logic       swap_detected,
    input wire logic       link_ready,
    input wire logic       clock_valid,
    input wire logic       phy_reset,
    input wire logic       pll_reset,
    input wire logic       swap_active
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    wire logic wr_two = reg_write && reg_addr == ADDR_DUAL_TWO;
    // ----------------
    // Properties
    // ----------------
    property p_pll_pulse; pll_reset |=> !pll_reset; endproperty
    a_pll_pulse: assert property (p_pll_pulse) else $error("pll reset too long");
    property p_phy_len; $rose(phy_reset) |-> phy_reset [*4]; endproperty
    a_phy_len: assert property (p_phy_len) else $error("phy reset too short");
    property p_link_ovr; wr_two && reg_wdata[LINK_RDY_OVR] |-> ##[1:3] link_ready; endproperty
    a_link_ovr: assert property (p_link_ovr) else $error("link ready not forced");
    property p_clk_ovr; wr_two && reg_wdata[CLK_PRESENT_OVR] |-> ##[1:3] clock_valid; endproperty
    a_clk_ovr: assert property (p_clk_ovr) else $error("clock valid not forced");
    property p_low_rsv; reg_addr == ADDR_LOW_LIMIT |-> !reg_rdata[7]; endproperty
    a_low_rsv: assert property (p_low_rsv) else $error("low limit bit7 set");
    property p_high_rsv; reg_addr == ADDR_HIGH_LIM |-> !reg_rdata[7]; endproperty
    a_high_rsv: assert property (p_high_rsv) else $error("high limit bit7 set");
    property p_stat_rsv; reg_addr == ADDR_STATUS |-> reg_rdata[7:2] == 6'h00; endproperty
    a_stat_rsv: assert property (p_stat_rsv) else $error("status upper bits set");
    property p_two_rw; $past(wr_two) && reg_addr == ADDR_DUAL_TWO |-> reg_rdata == $past(reg_wdata);
    endproperty
    a_two_rw: assert property (p_two_rw) else $error("control two readback wrong");
    // Swap state moves only on a detected swap or a register write
    property p_swap_cause; $changed(swap_active) |-> $past(swap_detected) ||
        $past(swap_detected, 2) || $past(reg_write) || $past(reg_write, 2); endproperty
    a_swap_cause: assert property (p_swap_cause) else $error("swap state moved alone");
endmodule

// File: testbench/tmds_source_model.sv
// Upstream source model: TMDS clock and receiver PLL clock
`timescale 1ns/1ps
module tmds_source_model #(
    parameter real TMDS_HALF = 62.5,
    parameter real PLL_HALF  = 50.0
) (
    // Control
    input  wire logic enable,
    // Clocks, parked low while the source is off
    output logic      tmds_clock,
    output logic      pll_clock
);
    initial begin
        tmds_clock = 1'b0;
        #1.3;
        forever #(TMDS_HALF) tmds_clock = enable & ~tmds_clock;
    end
    initial begin
        pll_clock = 1'b0;
        #0.7;
        forever #(PLL_HALF) pll_clock = enable & ~pll_clock;
    end
endmodule
